// ===== common/codec_pkg.sv
// Constants shared by the parameter quantiser / FEC codec.
// Gains are carried in 1/16 dB steps, voicing strengths as 8-bit fractions of one.
package codec_pkg;
  // Gain range and thresholds, 1/16 dB units
  localparam logic [10:0] GAIN_LO = 11'h0a0;
  localparam logic [10:0] GAIN_HI = 11'h4d0;
  localparam logic [10:0] GAIN_STEADY = 11'h050;
  localparam logic [10:0] GAIN_MEAN_TOL = 11'h030;
  localparam logic [10:0] GAIN_MARGIN = 11'h060;
  localparam logic [10:0] PAST_GAIN_RESET = 11'h000;
  localparam int GAIN2_STEPS = 31;
  localparam int GAIN1_STEPS = 6;
  // Strength above 0.6 of full scale
  localparam logic [7:0] VOICE_MIN = 8'h9a;
  localparam logic [3:0] VBAND_ODD = 4'h1;
  // Pitch quantiser
  localparam int PITCH_LO = 20;
  localparam int PITCH_HI = 160;
  localparam int PITCH_LEVELS = 99;
  localparam logic [7:0] PITCH_DEFAULT = 8'h32;
  localparam logic [7:0] JITTER_QUARTER = 8'h40;
  localparam logic [7:0] JITTER_NONE = 8'h00;
  // Peak picker
  localparam int FFT_POINTS = 512;
  localparam logic [3:0] MAX_HARMONICS = 4'ha;
  localparam logic [15:0] HARM_UNITY = 16'h0100;
  typedef enum logic [1:0] {
    PK_IDLE = 2'b00,
    PK_SETUP = 2'b01,
    PK_SCAN = 2'b10
  } pick_state_t;
endpackage : codec_pkg

// ===== design/vocoder_param_fec_codec.sv
// Speech-coder parameter quantiser, FEC packer, harmonic peak picker and
// FEC decoder / parameter reconstructor.
// Assumes one clock, all inputs synchronous to it, strobes one cycle long.
`timescale 1ns/1ns
`default_nettype none
module vocoder_param_fec_codec (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Encoder parameters from analysis
  input wire logic enc_strobe_in,
  input wire logic [7:0] final_pitch_in,
  input wire logic [10:0] first_gain_in,
  input wire logic [10:0] second_gain_in,
  input wire logic [7:0] voicing_in,
  input wire logic [31:0] band_strength_in,
  input wire logic [6:0] lsf_index1_in,
  input wire logic [7:0] fourier_code_in,
  input wire logic aperiodic_in,
  // Residual magnitude spectrum load
  input wire logic spec_wr_in,
  input wire logic [7:0] spec_addr_in,
  input wire logic [15:0] spec_data_in,
  // Packed frame to channel
  output logic enc_valid_out,
  output logic [6:0] tx_pitch_code_out,
  output logic [2:0] tx_first_gain_code_out,
  output logic [4:0] tx_second_gain_code_out,
  output logic [3:0] tx_voicing_out,
  output logic [6:0] tx_lsf_index1_out,
  output logic [7:0] tx_fourier_out,
  output logic tx_aperiodic_out,
  // Harmonic peaks to the magnitude quantiser
  output logic harm_valid_out,
  output logic [3:0] harm_num_out,
  output logic [15:0] harm_mag_out,
  output logic harm_missing_out,
  output logic pick_busy_out,
  // Packed frame from channel
  input wire logic dec_strobe_in,
  input wire logic rx_erasure_in,
  input wire logic [6:0] rx_pitch_code_in,
  input wire logic [2:0] rx_first_gain_code_in,
  input wire logic [4:0] rx_second_gain_code_in,
  input wire logic [3:0] rx_voicing_in,
  input wire logic [6:0] rx_lsf_index1_in,
  input wire logic [7:0] rx_fourier_in,
  input wire logic rx_aperiodic_in,
  // Decoded parameters
  output logic dec_valid_out,
  output logic dec_repeat_out,
  output logic [7:0] dec_pitch_out,
  output logic [7:0] dec_jitter_out,
  output logic dec_voiced_out,
  output logic [3:0] dec_band_out,
  output logic [7:0] dec_fourier_code_out,
  output logic dec_fourier_unity_out,
  output logic [6:0] dec_lsf_index1_out,
  output logic [10:0] dec_first_gain_out,
  output logic [10:0] dec_second_gain_out
);

  // Elaboration-time tables
  function automatic int pitch_to_level(int p);
    int q;
    q = p < codec_pkg::PITCH_LO ? codec_pkg::PITCH_LO : p;
    q = q > codec_pkg::PITCH_HI ? codec_pkg::PITCH_HI : q;
    return $rtoi(real'(codec_pkg::PITCH_LEVELS - 1) * $log10(real'(q) / 20.0)
      / $log10(8.0) + 0.5);
  endfunction : pitch_to_level

  function automatic int level_to_pitch(int l);
    return $rtoi(20.0 * $pow(8.0, real'(l) / real'(codec_pkg::PITCH_LEVELS - 1)) + 0.5);
  endfunction : level_to_pitch

  // Codes of weight three or more, in ascending order, carry the pitch levels
  function automatic int nth_code(int n);
    int k;
    int r;
    logic [6:0] c;
    k = 0;
    r = 0;
    for (int i = 0; i < 128; i++) begin
      c = 7'(i);
      if ($countones(c) >= 3) begin
        if (k == n) r = i;
        k++;
      end
    end
    return r;
  endfunction : nth_code

  function automatic int code_rank(int v);
    int k;
    logic [6:0] c;
    k = 0;
    for (int i = 0; i < v; i++) begin
      c = 7'(i);
      if ($countones(c) >= 3) k++;
    end
    return k;
  endfunction : code_rank

  // Gain quantisers
  function automatic logic [4:0] g2_quant(logic [10:0] g);
    int v;
    v = int'(g);
    if (v < int'(codec_pkg::GAIN_LO)) v = int'(codec_pkg::GAIN_LO);
    if (v > int'(codec_pkg::GAIN_HI)) v = int'(codec_pkg::GAIN_HI);
    v = v - int'(codec_pkg::GAIN_LO);
    return 5'((v * codec_pkg::GAIN2_STEPS + int'(codec_pkg::GAIN_HI - codec_pkg::GAIN_LO) / 2)
      / int'(codec_pkg::GAIN_HI - codec_pkg::GAIN_LO));
  endfunction : g2_quant

  function automatic logic [10:0] g2_level(logic [4:0] i);
    return 11'(int'(codec_pkg::GAIN_LO) + (int'(i) * int'(codec_pkg::GAIN_HI
      - codec_pkg::GAIN_LO) + codec_pkg::GAIN2_STEPS / 2) / codec_pkg::GAIN2_STEPS);
  endfunction : g2_level

  function automatic int g1_lo(logic [10:0] a, logic [10:0] b);
    int v;
    v = (a < b ? int'(a) : int'(b)) - int'(codec_pkg::GAIN_MARGIN);
    return v < int'(codec_pkg::GAIN_LO) ? int'(codec_pkg::GAIN_LO) : v;
  endfunction : g1_lo

  function automatic int g1_hi(logic [10:0] a, logic [10:0] b);
    int v;
    v = (a > b ? int'(a) : int'(b)) + int'(codec_pkg::GAIN_MARGIN);
    return v > int'(codec_pkg::GAIN_HI) ? int'(codec_pkg::GAIN_HI) : v;
  endfunction : g1_hi

  function automatic logic [2:0] g1_quant(logic [10:0] g, logic [10:0] a, logic [10:0] b);
    int lo;
    int hi;
    int v;
    lo = g1_lo(a, b);
    hi = g1_hi(a, b);
    v = int'(g) < lo ? lo : (int'(g) > hi ? hi : int'(g));
    return 3'(1 + ((v - lo) * codec_pkg::GAIN1_STEPS + (hi - lo) / 2) / (hi - lo));
  endfunction : g1_quant

  function automatic logic [10:0] g1_level(logic [2:0] i, logic [10:0] a, logic [10:0] b);
    int lo;
    int hi;
    lo = g1_lo(a, b);
    hi = g1_hi(a, b);
    return 11'(lo + ((int'(i) - 1) * (hi - lo) + codec_pkg::GAIN1_STEPS / 2)
      / codec_pkg::GAIN1_STEPS);
  endfunction : g1_level

  // Hamming (7,4) parity and single-error repair
  function automatic logic [2:0] ham_par(logic [3:0] d);
    return {d[1] ^ d[2] ^ d[3], d[0] ^ d[2] ^ d[3], d[0] ^ d[1] ^ d[3]};
  endfunction : ham_par

  function automatic logic [3:0] ham_fix(logic [3:0] d, logic [2:0] s);
    logic [3:0] f;
    f = d;
    case (s)
      3'h3: f[0] = ~d[0];
      3'h5: f[1] = ~d[1];
      3'h6: f[2] = ~d[2];
      3'h7: f[3] = ~d[3];
      default: f = d;
    endcase
    return f;
  endfunction : ham_fix

  wire logic [6:0] lvl_tab [256];
  wire logic [6:0] code_tab [128];
  wire logic [6:0] rank_tab [128];
  wire logic [7:0] pval_tab [128];
  for (genvar p = 0; p < 256; p++) begin : g_lvl
    assign lvl_tab[p] = 7'(pitch_to_level(p));
  end
  for (genvar l = 0; l < 128; l++) begin : g_code
    assign code_tab[l] = 7'(nth_code(l));
    assign rank_tab[l] = 7'(code_rank(l));
    assign pval_tab[l] = 8'(level_to_pitch(l < codec_pkg::PITCH_LEVELS ? l
      : codec_pkg::PITCH_LEVELS - 1));
  end

  // Encoder
  logic [10:0] enc_prev_g2;
  wire logic enc_voiced = voicing_in >= codec_pkg::VOICE_MIN;
  wire logic [6:0] enc_level = lvl_tab[final_pitch_in];
  wire logic [6:0] enc_pcode = enc_voiced ? code_tab[enc_level] : 7'h00;
  wire logic [7:0] enc_qpitch = pval_tab[enc_level];
  wire logic [4:0] enc_g2c = g2_quant(second_gain_in);
  wire logic [10:0] enc_g2q = g2_level(enc_g2c);
  wire logic [11:0] enc_g2sum = {1'b0, enc_g2q} + {1'b0, enc_prev_g2};
  wire logic [10:0] enc_g2mean = enc_g2sum[11:1];
  wire logic [10:0] enc_g2diff = enc_g2q > enc_prev_g2 ? enc_g2q - enc_prev_g2
    : enc_prev_g2 - enc_g2q;
  wire logic [10:0] enc_g1diff = first_gain_in > enc_g2mean ? first_gain_in - enc_g2mean
    : enc_g2mean - first_gain_in;
  wire logic enc_steady = enc_g2diff < codec_pkg::GAIN_STEADY
    && enc_g1diff < codec_pkg::GAIN_MEAN_TOL;
  wire logic [2:0] enc_g1c = enc_steady ? 3'h0
    : g1_quant(first_gain_in, enc_g2q, enc_prev_g2);
  wire logic [3:0] enc_bands;
  for (genvar b = 0; b < 4; b++) begin : g_band
    assign enc_bands[b] = enc_voiced && band_strength_in[8*b +: 8] >= codec_pkg::VOICE_MIN;
  end
  wire logic [3:0] enc_vband = enc_bands == codec_pkg::VBAND_ODD ? 4'h0 : enc_bands;
  wire logic [2:0] enc_p8 = ham_par(lsf_index1_in[6:3]);
  wire logic [3:0] enc_uv_band = {^{lsf_index1_in[6:3], enc_p8}, enc_p8};
  wire logic [2:0] enc_p_lsf = ham_par({lsf_index1_in[2:0], 1'b0});
  wire logic [2:0] enc_p_g2 = ham_par(enc_g2c[4:1]);
  wire logic [2:0] enc_p_g1 = ham_par({enc_g2c[0], enc_g1c});
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      enc_valid_out <= 1'b0;
      tx_pitch_code_out <= 7'h00;
      tx_first_gain_code_out <= 3'h0;
      tx_second_gain_code_out <= 5'h00;
      tx_voicing_out <= 4'h0;
      tx_lsf_index1_out <= 7'h00;
      tx_fourier_out <= 8'h00;
      tx_aperiodic_out <= 1'b0;
      enc_prev_g2 <= codec_pkg::PAST_GAIN_RESET;
    end else begin
      enc_valid_out <= enc_strobe_in;
      if (enc_strobe_in) begin
        tx_pitch_code_out <= enc_pcode;
        tx_first_gain_code_out <= enc_g1c;
        tx_second_gain_code_out <= enc_g2c;
        tx_lsf_index1_out <= lsf_index1_in;
        tx_voicing_out <= enc_voiced ? enc_vband : enc_uv_band;
        tx_fourier_out <= enc_voiced ? fourier_code_in
          : {enc_p_lsf, enc_p_g2, enc_p_g1[2:1]};
        tx_aperiodic_out <= enc_voiced ? aperiodic_in : enc_p_g1[0];
        enc_prev_g2 <= enc_g2q;
      end
    end
  end

  // Harmonic peak picker over the loaded magnitude spectrum
  logic [15:0] spec_mem [256];
  codec_pkg::pick_state_t pk_state;
  logic [7:0] pk_pitch;
  logic [3:0] pk_harm;
  logic [8:0] pk_bin;
  logic [7:0] pk_left;
  logic [15:0] pk_max;
  wire logic [3:0] pk_count = pk_pitch >= 8'h28 ? codec_pkg::MAX_HARMONICS
    : 4'(pk_pitch >> 2);
  wire logic [8:0] pk_center = 9'((codec_pkg::FFT_POINTS * int'(pk_harm)) / int'(pk_pitch));
  wire logic [7:0] pk_width = 8'(codec_pkg::FFT_POINTS / int'(pk_pitch));
  wire logic [15:0] pk_sample = spec_mem[pk_bin[7:0]];
  wire logic [15:0] pk_best = pk_sample > pk_max ? pk_sample : pk_max;
  wire logic pk_last_harm = pk_harm == codec_pkg::MAX_HARMONICS;
  always_ff @(posedge clk_sys_in) begin
    if (spec_wr_in) begin
      spec_mem[spec_addr_in] <= spec_data_in;
    end
  end
  assign pick_busy_out = pk_state != codec_pkg::PK_IDLE;
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      pk_state <= codec_pkg::PK_IDLE;
      pk_pitch <= 8'(codec_pkg::PITCH_LO);
      pk_harm <= 4'h0;
      pk_bin <= 9'h000;
      pk_left <= 8'h00;
      pk_max <= 16'h0000;
      harm_valid_out <= 1'b0;
      harm_num_out <= 4'h0;
      harm_mag_out <= 16'h0000;
      harm_missing_out <= 1'b0;
    end else begin
      harm_valid_out <= 1'b0;
      case (pk_state)
        codec_pkg::PK_IDLE: begin
          pk_harm <= 4'h1;
        end
        codec_pkg::PK_SETUP: begin
          if (pk_harm > pk_count) begin
            harm_valid_out <= 1'b1;
            harm_num_out <= pk_harm;
            harm_mag_out <= codec_pkg::HARM_UNITY;
            harm_missing_out <= 1'b1;
            pk_harm <= pk_harm + 4'h1;
            if (pk_last_harm) pk_state <= codec_pkg::PK_IDLE;
          end else begin
            pk_bin <= pk_center - 9'(pk_width >> 1);
            pk_left <= pk_width;
            pk_max <= 16'h0000;
            pk_state <= codec_pkg::PK_SCAN;
          end
        end
        codec_pkg::PK_SCAN: begin
          pk_max <= pk_best;
          pk_bin <= pk_bin + 9'h001;
          pk_left <= pk_left - 8'h01;
          if (pk_left == 8'h01) begin
            harm_valid_out <= 1'b1;
            harm_num_out <= pk_harm;
            harm_mag_out <= pk_best;
            harm_missing_out <= 1'b0;
            pk_harm <= pk_harm + 4'h1;
            pk_state <= pk_last_harm ? codec_pkg::PK_IDLE : codec_pkg::PK_SETUP;
          end
        end
        default: pk_state <= codec_pkg::PK_IDLE;
      endcase
      if (enc_strobe_in) begin
        pk_pitch <= enc_qpitch;
        pk_harm <= 4'h1;
        pk_state <= codec_pkg::PK_SETUP;
      end
    end
  end

  // Decoder
  logic [10:0] past_g2;
  logic past_gain_error_flag;
  wire logic [2:0] dec_weight = 3'($countones(rx_pitch_code_in));
  wire logic dec_unv = dec_weight <= 3'h1;
  wire logic [2:0] dec_s8 = ham_par(rx_lsf_index1_in[6:3]) ^ rx_voicing_in[2:0];
  wire logic dec_ov = ^{rx_lsf_index1_in[6:3], rx_voicing_in};
  wire logic dec_double = dec_s8 != 3'h0 && !dec_ov;
  wire logic dec_erase = rx_erasure_in || dec_weight == 3'h2
    || (dec_unv && dec_double);
  wire logic [3:0] dec_hi = ham_fix(rx_lsf_index1_in[6:3], dec_s8);
  wire logic [3:0] dec_lo = ham_fix({rx_lsf_index1_in[2:0], 1'b0},
    ham_par({rx_lsf_index1_in[2:0], 1'b0}) ^ rx_fourier_in[7:5]);
  wire logic [3:0] dec_g2hi = ham_fix(rx_second_gain_code_in[4:1],
    ham_par(rx_second_gain_code_in[4:1]) ^ rx_fourier_in[4:2]);
  wire logic [3:0] dec_n3 = ham_fix({rx_second_gain_code_in[0], rx_first_gain_code_in},
    ham_par({rx_second_gain_code_in[0], rx_first_gain_code_in})
    ^ {rx_fourier_in[1:0], rx_aperiodic_in});
  wire logic [6:0] dec_lsf = dec_unv ? {dec_hi, dec_lo[3:1]} : rx_lsf_index1_in;
  wire logic [4:0] second_gain_code = dec_unv ? {dec_g2hi, dec_n3[3]}
    : rx_second_gain_code_in;
  wire logic [2:0] first_gain_code = dec_unv ? dec_n3[2:0] : rx_first_gain_code_in;
  wire logic [10:0] dec_g2 = g2_level(second_gain_code);
  wire logic [10:0] dec_g2diff = dec_g2 > past_g2 ? dec_g2 - past_g2 : past_g2 - dec_g2;
  wire logic dec_jump = first_gain_code == 3'h0 && dec_g2diff > codec_pkg::GAIN_STEADY;
  wire logic [10:0] dec_g2f = dec_jump && !past_gain_error_flag ? past_g2 : dec_g2;
  wire logic [11:0] dec_sum = {1'b0, dec_g2f} + {1'b0, past_g2};
  wire logic [10:0] dec_g1 = first_gain_code == 3'h0 ? dec_sum[11:1]
    : g1_level(first_gain_code, dec_g2, past_g2);
  wire logic [3:0] dec_vb = rx_voicing_in == codec_pkg::VBAND_ODD ? 4'h0 : rx_voicing_in;
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      dec_valid_out <= 1'b0;
      dec_repeat_out <= 1'b0;
      dec_pitch_out <= codec_pkg::PITCH_DEFAULT;
      dec_jitter_out <= codec_pkg::JITTER_NONE;
      dec_voiced_out <= 1'b0;
      dec_band_out <= 4'h0;
      dec_fourier_code_out <= 8'h00;
      dec_fourier_unity_out <= 1'b1;
      dec_lsf_index1_out <= 7'h00;
      dec_first_gain_out <= codec_pkg::GAIN_LO;
      dec_second_gain_out <= codec_pkg::GAIN_LO;
      past_g2 <= codec_pkg::PAST_GAIN_RESET;
      past_gain_error_flag <= 1'b0;
    end else begin
      dec_valid_out <= dec_strobe_in;
      if (dec_strobe_in) begin
        dec_repeat_out <= dec_erase;
        if (dec_erase) begin
          dec_first_gain_out <= dec_second_gain_out;
        end else begin
          dec_lsf_index1_out <= dec_lsf;
          dec_second_gain_out <= dec_g2f;
          dec_first_gain_out <= dec_g1;
          past_g2 <= dec_g2f;
          past_gain_error_flag <= dec_jump;
          dec_voiced_out <= !dec_unv;
          dec_fourier_unity_out <= dec_unv;
          dec_fourier_code_out <= rx_fourier_in;
          if (dec_unv) begin
            dec_pitch_out <= codec_pkg::PITCH_DEFAULT;
            dec_jitter_out <= codec_pkg::JITTER_QUARTER;
            dec_band_out <= 4'h0;
          end else begin
            dec_pitch_out <= pval_tab[rank_tab[rx_pitch_code_in]];
            dec_jitter_out <= rx_aperiodic_in ? codec_pkg::JITTER_QUARTER
              : codec_pkg::JITTER_NONE;
            dec_band_out <= dec_vb;
          end
        end
      end
    end
  end

  unvoiced_pitch_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    enc_strobe_in && voicing_in < codec_pkg::VOICE_MIN |=> enc_valid_out
    && tx_pitch_code_out == 7'h00) else $error("unvoiced frame sent nonzero pitch");
  pitch_weight_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    enc_valid_out |-> $countones(tx_pitch_code_out) != 1
    && $countones(tx_pitch_code_out) != 2) else $error("reserved pitch code sent");
  gain_code_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    enc_strobe_in |=> tx_second_gain_code_out == g2_quant($past(second_gain_in)))
    else $error("second gain code wrong");
  band_pattern_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    enc_valid_out && tx_pitch_code_out != 7'h00 |-> tx_voicing_out != codec_pkg::VBAND_ODD)
    else $error("band pattern 0001 sent");
  unvoiced_parity_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    enc_valid_out && tx_pitch_code_out == 7'h00
    |-> tx_voicing_out[2:0] == ham_par(tx_lsf_index1_out[6:3]))
    else $error("band bits lack parity");
  erasure_repeat_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    dec_strobe_in && rx_erasure_in |=> dec_repeat_out
    && dec_first_gain_out == $past(dec_second_gain_out)
    && dec_pitch_out == $past(dec_pitch_out)) else $error("erasure did not repeat frame");
  unvoiced_default_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    dec_valid_out && !dec_repeat_out && !dec_voiced_out
    |-> dec_pitch_out == codec_pkg::PITCH_DEFAULT && dec_band_out == 4'h0
    && dec_jitter_out == codec_pkg::JITTER_QUARTER && dec_fourier_unity_out)
    else $error("unvoiced defaults wrong");
  harm_count_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    harm_valid_out && !harm_missing_out |-> int'(harm_num_out) <= int'(pk_pitch) / 4)
    else $error("too many harmonics searched");

endmodule : vocoder_param_fec_codec
`default_nettype wire

// ===== verif/channel_model.sv
// Channel model: loops each packed encoder frame back to the decoder.
// Assumes tx fields are valid while enc_valid_in is high.
`timescale 1ns/1ns
`default_nettype none
module channel_model (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Frame from encoder and fault controls
  input wire logic enc_valid_in,
  input wire logic [34:0] tx_in,
  input wire logic [34:0] flip_in,
  input wire logic erase_in,
  // Frame to decoder
  output logic dec_strobe_out,
  output logic erasure_out,
  output logic [34:0] rx_out
);
  // Outside the strobe cycle the erasure and frame lines toggle, so nothing stale looks valid
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      dec_strobe_out <= 1'b0;
      erasure_out <= 1'b0;
      rx_out <= '0;
    end else if (enc_valid_in) begin
      dec_strobe_out <= 1'b1;
      erasure_out <= erase_in;
      rx_out <= tx_in ^ flip_in;
    end else begin
      dec_strobe_out <= 1'b0;
      erasure_out <= ~erasure_out;
      rx_out <= ~rx_out;
    end
  end
endmodule : channel_model
`default_nettype wire

// ===== verif/tb_top.sv
// Bench: encoder frames loop through the channel model into the decoder.
// Assumes a ramp spectrum, so each peak is the top bin of its search window.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic enc_go = 1'b0;
  logic [7:0] pitch = 8'h32;
  logic [10:0] g1 = 11'h4d0;
  logic [10:0] g2 = 11'h4d0;
  logic [7:0] vo = 8'hff;
  logic [31:0] bands = 32'h000000c0;
  logic [6:0] lsf = 7'h5a;
  logic ap = 1'b1;
  logic [34:0] flip = '0;
  logic erase = 1'b0;
  wire [34:0] tx;
  wire [34:0] rx;
  wire enc_v, dec_go, rx_er, dec_v, rep, voiced, unity, hv, hm;
  wire [7:0] d_pitch, d_jit;
  wire [3:0] d_band;
  wire [6:0] d_lsf;
  wire [10:0] d_g1, d_g2;
  wire [3:0] h_num;
  wire [15:0] h_mag;
  wire busy;
  wire [7:0] d_four;
  logic spec_wr = 1'b0;
  logic [7:0] spec_addr = 8'h00;
  logic [15:0] spec_data = 16'h0000;
  logic [3:0] last_num = 4'h0;
  logic [15:0] last_mag = 16'h0000;
  int err_total = 0;
  int tests_run = 0;
  int harm_seen = 0;
  int miss_seen = 0;
  vocoder_param_fec_codec i_dut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .enc_strobe_in(enc_go),
    .final_pitch_in(pitch), .first_gain_in(g1), .second_gain_in(g2), .voicing_in(vo),
    .band_strength_in(bands), .lsf_index1_in(lsf), .fourier_code_in(8'h3c), .aperiodic_in(ap),
    .spec_wr_in(spec_wr), .spec_addr_in(spec_addr), .spec_data_in(spec_data),
    .enc_valid_out(enc_v), .tx_pitch_code_out(tx[34:28]), .tx_first_gain_code_out(tx[27:25]),
    .tx_second_gain_code_out(tx[24:20]), .tx_voicing_out(tx[19:16]),
    .tx_lsf_index1_out(tx[15:9]), .tx_fourier_out(tx[8:1]), .tx_aperiodic_out(tx[0]),
    .harm_valid_out(hv), .harm_num_out(h_num), .harm_mag_out(h_mag), .harm_missing_out(hm),
    .pick_busy_out(busy), .dec_strobe_in(dec_go), .rx_erasure_in(rx_er),
    .rx_pitch_code_in(rx[34:28]), .rx_first_gain_code_in(rx[27:25]),
    .rx_second_gain_code_in(rx[24:20]), .rx_voicing_in(rx[19:16]),
    .rx_lsf_index1_in(rx[15:9]), .rx_fourier_in(rx[8:1]), .rx_aperiodic_in(rx[0]),
    .dec_valid_out(dec_v), .dec_repeat_out(rep), .dec_pitch_out(d_pitch),
    .dec_jitter_out(d_jit), .dec_voiced_out(voiced), .dec_band_out(d_band),
    .dec_fourier_code_out(d_four), .dec_fourier_unity_out(unity), .dec_lsf_index1_out(d_lsf),
    .dec_first_gain_out(d_g1), .dec_second_gain_out(d_g2));
  channel_model i_chan (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .enc_valid_in(enc_v),
    .tx_in(tx), .flip_in(flip), .erase_in(erase), .dec_strobe_out(dec_go),
    .erasure_out(rx_er), .rx_out(rx));
  initial begin
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  always @(negedge clk_sys_in) begin
    if (hv === 1'b1) begin
      harm_seen++;
      last_num = h_num;
      last_mag = h_mag;
    end
    if (hv === 1'b1 && hm === 1'b1) miss_seen++;
  end
  function automatic logic [2:0] par(input logic [3:0] d);
    return {d[1] ^ d[2] ^ d[3], d[0] ^ d[2] ^ d[3], d[0] ^ d[1] ^ d[3]};
  endfunction : par
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // One strobe, then wait for the looped-back frame to be decoded
  task automatic frame();
    int i;
    @(posedge clk_sys_in);
    enc_go <= 1'b1;
    @(posedge clk_sys_in);
    enc_go <= 1'b0;
    for (i = 0; i < 8 && dec_v !== 1'b1; i++) @(negedge clk_sys_in);
    if (dec_v !== 1'b1) begin
      err_total++;
      end_sim();
    end
  endtask : frame
  task automatic s_reset();
    chk("enc valid", enc_v, 0);
    chk("reset pitch", d_pitch, 8'h32);
    chk("reset unity", unity, 1);
    chk("reset gain", d_g2, 11'h0a0);
  endtask : s_reset
  task automatic s_voiced();
    int i;
    for (i = 0; i < 256; i++) begin
      @(posedge clk_sys_in);
      spec_wr <= 1'b1;
      spec_addr <= 8'(i);
      spec_data <= 16'(i);
    end
    @(posedge clk_sys_in);
    spec_wr <= 1'b0;
    harm_seen = 0;
    frame();
    chk("busy", busy, 1);
    chk("fourier code", d_four, 8'h3c);
    chk("band code", tx[19:16], 4'h0);
    chk("pitch weight", $countones(tx[34:28]) >= 3, 1);
    chk("g2 code", tx[24:20], 5'h1f);
    chk("g1 code", tx[27:25] != 3'h0, 1);
    chk("voiced", voiced, 1);
    chk("jitter", d_jit, 8'h40);
    chk("g2", d_g2, 11'h4d0);
    for (i = 0; i < 400 && harm_seen < 10; i++) @(negedge clk_sys_in);
    chk("harmonics", harm_seen, 10);
    chk("missing", miss_seen, 0);
    chk("last harmonic", last_num, 4'ha);
    chk("last peak", last_mag, 16'h006a);
    chk("idle", busy, 0);
  endtask : s_voiced
  task automatic s_gain_jump();
    @(posedge clk_sys_in);
    ap <= 1'b0;
    bands <= 32'hc020c0c0;
    flip <= 35'h1 << 24;
    frame();
    chk("steady code", tx[27:25], 3'h0);
    chk("band code", tx[19:16], 4'hb);
    chk("bands", d_band, 4'hb);
    chk("jitter", d_jit, 8'h00);
    chk("g2 kept", d_g2, 11'h4d0);
    chk("g1 mean", d_g1, 11'h4d0);
    frame();
    chk("g2 passed", d_g2, 11'h2a7);
    chk("g1 mean 2", d_g1, 11'h3bb);
  endtask : s_gain_jump
  task automatic s_erase();
    flip <= '0;
    erase <= 1'b1;
    frame();
    chk("repeat", rep, 1);
    chk("g2 held", d_g2, 11'h2a7);
    chk("g1 as g2", d_g1, 11'h2a7);
    chk("jitter held", d_jit, 8'h00);
    erase <= 1'b0;
  endtask : s_erase
  task automatic s_unvoiced();
    logic [2:0] pv;
    int i;
    @(posedge clk_sys_in);
    vo <= 8'h20;
    pitch <= 8'h14;
    flip <= 35'h1 << 15;
    pv = par(lsf[6:3]);
    harm_seen = 0;
    miss_seen = 0;
    frame();
    chk("unvoiced code", tx[34:28], 7'h00);
    chk("band parity", tx[19:16], {^{lsf[6:3], pv}, pv});
    chk("lsf parity", tx[8:6], par({lsf[2:0], 1'b0}));
    chk("g2 parity", tx[5:3], par(4'hf));
    chk("g1 parity", tx[2:0], par(4'h8));
    chk("lsf fixed", d_lsf, 7'h5a);
    chk("pitch", d_pitch, 8'h32);
    chk("jitter", d_jit, 8'h40);
    chk("bands", d_band, 4'h0);
    chk("unity", unity, 1);
    for (i = 0; i < 400 && harm_seen < 10; i++) @(negedge clk_sys_in);
    chk("harmonics 2", harm_seen, 10);
    chk("missing 2", miss_seen, 5);
    chk("unity peak", last_mag, 16'h0100);
  endtask : s_unvoiced
  task automatic s_mode();
    logic [34:0] masks [3] = '{35'h1 << 28, 35'h3 << 28, 35'h3 << 14};
    logic exp_rep [3] = '{1'b0, 1'b1, 1'b1};
    for (int k = 0; k < 3; k++) begin
      flip <= masks[k];
      frame();
      chk("mode repeat", rep, exp_rep[k]);
    end
  endtask : s_mode
  task automatic end_sim();
    if (err_total == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (20) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(negedge clk_sys_in);
    s_reset();
    s_voiced();
    s_gain_jump();
    s_erase();
    s_unvoiced();
    s_mode();
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
